// ### hdl/tcs_pkg.sv
// Package for the touch channel selector: widths, codes and decode ranges.
// Assumes a single 125 MHz clock domain and synchronous active-low reset.
package tcs_pkg;
	localparam int          CNT_W       = 4;
	localparam int          NUM_CH      = 10;
	localparam logic [3:0]  CNT_RESET   = 4'h0;
	localparam logic [3:0]  CNT_STEP    = 4'h1;
	localparam logic [3:0]  BASE_LO     = 4'h0;
	localparam logic [3:0]  EXP_LO      = 4'h6;
	localparam int          SYNC_STAGES = 2;
	// Variant selector.
	typedef enum logic [0:0] {
		TCS_BASIC    = 1'b0,
		TCS_EXPANDER = 1'b1
	} tcs_variant_t;
	// Load sequencer states.
	typedef enum logic [1:0] {
		TCS_PRESET = 2'b00,
		TCS_IDLE   = 2'b01,
		TCS_LOAD   = 2'b10
	} tcs_state_t;
endpackage : tcs_pkg

// ### hdl/tcs_dec_if.sv
// Interface carrying the counter value from the selector core to its decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface tcs_dec_if;
	logic [3:0] code;
	logic [9:0] sel_n;
	modport core (output code, input  sel_n);
	modport dec  (input  code, output sel_n);
endinterface : tcs_dec_if

// ### hdl/tcs_decoder.sv
// Four-to-ten channel decoder with a selectable base code.
// Assumes the code input is stable within one clock cycle.
`timescale 1ns/1ns
module tcs_decoder #(
	parameter logic [3:0] BASE = 4'h0
) (
	// Code in, active-low selects out.
	tcs_dec_if.dec d
);
	// One output low for codes BASE..BASE+9; all high otherwise.
	always_comb begin
		logic [4:0] rel;
		rel = {1'b0, d.code} - {1'b0, BASE};
		d.sel_n = 10'h3ff;
		if (d.code >= BASE && rel < 5'(tcs_pkg::NUM_CH)) begin
			d.sel_n[rel[3:0]] = 1'b0;
		end
	end
endmodule : tcs_decoder

// ### hdl/tcs_selector.sv
// Touch channel selector core: down counter, parallel load, decode, mute.
// Assumes pad and enable inputs are synchronous and touch stops by pad match.
`timescale 1ns/1ns
// Contract
// - Each clock pulse decrements the counter, stepping through outputs one at a time.
// - The counter is decoded so at most one channel output is low; codes outside the decode range leave all high.
// - When the touched channel output becomes active the clock is stopped and held.
// - Outside a parallel load the basic variant drives the counter value on the address pins.
// - A parallel load captures the address pins when enable is released, then holds.
// - At power-up the address lines and counter are forced to zero, channel one; the expander drives its pins only while reset is held and selects no channel.
// - Mute is asserted while clocking is active, enable is active, or preset applies.
// - The clock input accepts external pulses which step the selection.
// - Address outputs present the counter as plain binary 0000 to 1111.
// - The counter cycles through all 16 states with no shortened modulus.
// - The basic decoder answers codes 0000 to 1001, the expander 0110 to 1111.
// - The expander counter is a transparent register passing the address lines.
module tcs_selector #(
	parameter tcs_pkg::tcs_variant_t VARIANT   = tcs_pkg::TCS_BASIC,
	parameter int                    PRESET_CY = 4
) (
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	// Touch pads, one per channel, high while touched.
	input  wire logic [9:0] i_touch,
	// External step pulse input, high pulse per step.
	input  wire logic       i_step,
	// Parallel load enable, active low.
	input  wire logic       i_load_en_n,
	// Two-way binary address pins.
	input  wire logic [3:0] i_addr,
	output logic      [3:0] o_addr,
	output logic      [3:0] o_addr_oe,
	// Channel outputs, active low.
	output logic      [9:0] o_chan_n,
	// Mute output, high while muted.
	output logic            o_mute
);
	initial begin
		if (PRESET_CY < 1 || PRESET_CY > 255) $error("PRESET_CY out of range");
	end

	localparam bit EXP = (VARIANT == tcs_pkg::TCS_EXPANDER);

	tcs_pkg::tcs_state_t state_reg;
	logic [3:0]          cnt_reg;
	logic [7:0]          pre_reg;
	logic                step_s1_reg;
	logic                step_s2_reg;
	logic                step_d_reg;
	logic                run_reg;
	logic                step_seen_reg;
	logic                en_d_reg;
	logic [9:0]          touch_hit;
	logic                step_edge;
	logic                en_rise;
	tcs_dec_if           dec_bus ();

	tcs_decoder #(
		.BASE (EXP ? tcs_pkg::EXP_LO : tcs_pkg::BASE_LO)
	) u_dec (
		.d (dec_bus.dec)
	);
	assign dec_bus.code = cnt_reg;

	// Two-flop synchroniser on the step pin, then a rising edge detector.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			step_s1_reg <= 1'b0;
			step_s2_reg <= 1'b0;
			step_d_reg  <= 1'b0;
		end else begin
			step_s1_reg <= i_step;
			step_s2_reg <= step_s1_reg;
			step_d_reg  <= step_s2_reg;
		end
	end
	assign step_edge = step_s2_reg && !step_d_reg;

	// A touched pad whose output is active acts as the clock shunt.
	assign touch_hit = i_touch & ~dec_bus.sel_n;

	// Internal oscillator runs while a pad is touched and no touched channel is selected, basic variant only.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			run_reg <= 1'b0;
		end else begin
			run_reg <= (|i_touch) && !(|touch_hit) && !EXP;
		end
	end

	// Release edge of the load enable.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			en_d_reg <= 1'b0;
		end else begin
			en_d_reg <= !i_load_en_n;
		end
	end
	assign en_rise = en_d_reg && i_load_en_n;

	// Preset, idle and load sequencing.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			state_reg <= tcs_pkg::TCS_PRESET;
			pre_reg   <= 8'h00;
		end else begin
			case (state_reg)
				tcs_pkg::TCS_PRESET: begin
					pre_reg <= pre_reg + 8'h01;
					if (pre_reg == 8'(PRESET_CY - 1)) begin
						state_reg <= tcs_pkg::TCS_IDLE;
					end
				end
				tcs_pkg::TCS_IDLE: begin
					if (!i_load_en_n && !EXP) begin
						state_reg <= tcs_pkg::TCS_LOAD;
					end
				end
				tcs_pkg::TCS_LOAD: begin
					if (i_load_en_n) begin
						state_reg <= tcs_pkg::TCS_IDLE;
					end
				end
				default: begin
					state_reg <= tcs_pkg::TCS_PRESET;
				end
			endcase
		end
	end

	// Counter: zero at preset, load on release, else step down by one.
	// Wrap from 0 to 15 is natural, so all sixteen codes are visited.
	// The oscillator step is also gated by the live pad match, because the registered
	// run flag lags by one cycle and would otherwise step past the touched channel.
	// The load uses the release edge of the enable, so a held enable never reloads.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			cnt_reg <= tcs_pkg::CNT_RESET;
		end else if (state_reg == tcs_pkg::TCS_PRESET) begin
			cnt_reg <= tcs_pkg::CNT_RESET;
		end else if (EXP) begin
			cnt_reg <= i_addr;
		end else if (state_reg == tcs_pkg::TCS_LOAD && en_rise) begin
			cnt_reg <= i_addr;
		end else if (state_reg == tcs_pkg::TCS_IDLE
			&& ((run_reg && !(|touch_hit)) || step_edge)) begin
			cnt_reg <= cnt_reg - tcs_pkg::CNT_STEP;
		end
	end

	// Registered outputs; address pins driven by the basic variant except while loading.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_addr    <= tcs_pkg::CNT_RESET;
			o_addr_oe <= 4'hf;
			o_chan_n  <= 10'h3ff;
		end else begin
			o_addr    <= cnt_reg;
			o_addr_oe <= {4{!EXP && state_reg != tcs_pkg::TCS_LOAD && i_load_en_n}};
			o_chan_n  <= dec_bus.sel_n;
		end
	end

	// Mute follows clock activity, enable and preset.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			o_mute        <= 1'b1;
			step_seen_reg <= 1'b0;
		end else begin
			step_seen_reg <= step_s2_reg;
			o_mute <= run_reg || step_seen_reg || !i_load_en_n
				|| state_reg == tcs_pkg::TCS_PRESET;
		end
	end

	// Checks.
	AST_PRESET_ZERO: assert property (@(posedge i_clk) disable iff (!i_nrst)
		state_reg == tcs_pkg::TCS_PRESET |=> cnt_reg == tcs_pkg::CNT_RESET)
		else $error("counter not zero during preset");
	AST_STEP_DEC: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(state_reg == tcs_pkg::TCS_IDLE && step_edge && !EXP && i_load_en_n)
		|=> cnt_reg == $past(cnt_reg) - 4'h1)
		else $error("step did not decrement");
	AST_ONEHOT: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$countones(~o_chan_n) <= 1)
		else $error("more than one channel active");
	AST_STOP: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(|touch_hit) |=> !run_reg)
		else $error("clock not stopped at touched channel");
	AST_TOUCH_HOLD: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(state_reg == tcs_pkg::TCS_IDLE && (|touch_hit) && !step_edge && !EXP)
		|=> $stable(cnt_reg))
		else $error("counter moved past the touched channel");
	AST_MUTE_PRESET: assert property (@(posedge i_clk) disable iff (!i_nrst)
		state_reg == tcs_pkg::TCS_PRESET |=> o_mute)
		else $error("mute missing during preset");
	AST_EXP_PASS: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(EXP && state_reg == tcs_pkg::TCS_IDLE)
		|=> cnt_reg == $past(i_addr))
		else $error("expander register not transparent");
	AST_ADDR_OUT: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_addr_oe == 4'hf |-> o_addr == $past(cnt_reg))
		else $error("address pins not showing counter");
	AST_LOAD: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(state_reg == tcs_pkg::TCS_LOAD && i_load_en_n) |=> cnt_reg == $past(i_addr))
		else $error("load not captured on release");
	AST_NO_DRIVE_LOAD: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!i_load_en_n |=> o_addr_oe == 4'h0)
		else $error("address driven during load");
	AST_MUTE: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(!i_load_en_n || run_reg) |=> o_mute)
		else $error("mute missing");
	AST_WRAP: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(cnt_reg == 4'h0 && step_edge && state_reg == tcs_pkg::TCS_IDLE
		&& !EXP && i_load_en_n) |=> cnt_reg == 4'hf)
		else $error("counter did not wrap to 15");
endmodule : tcs_selector

// ### tb/tcs_remote.sv
// Remote controller model: step pulses and direct code loads over enable.
// Assumes the bench asks for one operation at a time, spaced apart.
`timescale 1ns/1ns
module tcs_remote (
	input  wire logic       i_clk,
	input  wire logic       i_go_load,
	input  wire logic       i_go_step,
	input  wire logic       i_go_six,
	input  wire logic [3:0] i_code,
	output logic            o_step,
	output logic            o_load_en_n,
	output logic      [3:0] o_addr
);
	logic [1:0] cnt_reg;
	logic [3:0] six_reg;
	logic [3:0] code_reg;
	logic [3:0] six_next;
	// Idle levels at time zero.
	initial begin
		o_step = 1'b0;
		o_load_en_n = 1'b1;
		o_addr = 4'h0;
		cnt_reg = 2'h0;
		six_reg = 4'h0;
		code_reg = 4'h0;
	end
	// Outside six-step counter that returns to zero on every sixth pulse.
	assign six_next = (six_reg == 4'h5) ? 4'h0 : six_reg + 4'h1;
	// Enable stays low for three cycles with the code standing on the pins; released pins
	// show the inverse code so a stale value is never mistaken for a driven one.
	always @(posedge i_clk) begin
		o_step <= i_go_step;
		if (i_go_six)
			six_reg <= six_next;
		if (i_go_load)
			code_reg <= i_code;
		else if (i_go_six)
			code_reg <= six_next;
		if (i_go_load || i_go_six)
			cnt_reg <= 2'h3;
		else if (cnt_reg != 2'h0)
			cnt_reg <= cnt_reg - 2'h1;
		o_load_en_n <= !(i_go_load || i_go_six || cnt_reg > 2'h1);
		if (i_go_load)
			o_addr <= i_code;
		else if (i_go_six)
			o_addr <= six_next;
		else if (cnt_reg != 2'h0)
			o_addr <= code_reg;
		else
			o_addr <= ~code_reg;
	end
endmodule : tcs_remote

// ### tb/test_touch_channel_selector.sv
// Testbench for the selector: reset, step, load, touch stop and expander decode.
// Assumes the remote model drives step, enable and address while loading.
`timescale 1ns/1ns
module test_touch_channel_selector;
	logic       i_clk = 1'b0;
	logic       i_nrst = 1'b0;
	logic       go_load = 1'b0;
	logic       go_step = 1'b0;
	logic       go_six = 1'b0;
	logic [3:0] xout;
	logic [9:0] touch = 10'h000;
	logic [3:0] code = 4'h0;
	logic [3:0] xaddr = 4'h0;
	logic       step, load_en_n, mute;
	logic [3:0] raddr, pad, addr, oe;
	logic [9:0] chan_n, xchan_n;
	int         n_errors = 0;
	int         comparisons = 0;
	// The 125 MHz clock.
	always #4 i_clk = ~i_clk;
	// Pin level: the device wins on every bit it drives.
	assign pad = (oe & addr) | (~oe & raddr);
	tcs_remote i_tcs_remote (.i_clk(i_clk), .i_go_load(go_load), .i_go_step(go_step),
		.i_go_six(go_six), .i_code(code), .o_step(step), .o_load_en_n(load_en_n),
		.o_addr(raddr));
	tcs_selector i_tcs_selector (.i_clk(i_clk), .i_nrst(i_nrst), .i_touch(touch),
		.i_step(step), .i_load_en_n(load_en_n), .i_addr(pad), .o_addr(addr),
		.o_addr_oe(oe), .o_chan_n(chan_n), .o_mute(mute));
	tcs_selector #(.VARIANT(tcs_pkg::TCS_EXPANDER)) i_tcs_selector_x (.i_clk(i_clk),
		.i_nrst(i_nrst), .i_touch(10'h000), .i_step(1'b0), .i_load_en_n(1'b1),
		.i_addr(xaddr), .o_addr(xout), .o_addr_oe(), .o_chan_n(xchan_n), .o_mute());
	task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic print_verdict;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cyc
	task automatic pulse;
		@(posedge i_clk) go_step <= 1'b1;
		@(posedge i_clk) go_step <= 1'b0;
		cyc(8);
	endtask : pulse
	task automatic t_reset;
		cyc(4);
		check("mute in reset", 10'h001, mute);
		check("chan in reset", 10'h3ff, chan_n);
		@(posedge i_clk) i_nrst <= 1'b1;
		cyc(12);
		check("addr preset", 10'h000, addr);
		check("chan preset", 10'h3fe, chan_n);
		check("mute idle", 10'h000, mute);
	endtask : t_reset
	task automatic t_step;
		pulse();
		check("addr wrap", 10'h00f, addr);
		check("chan none", 10'h3ff, chan_n);
		pulse();
		check("addr step", 10'h00e, addr);
	endtask : t_step
	task automatic t_load;
		@(posedge i_clk) code <= 4'h9;
		go_load <= 1'b1;
		@(posedge i_clk) go_load <= 1'b0;
		cyc(2);
		check("oe in load", 10'h000, oe);
		check("mute in load", 10'h001, mute);
		cyc(6);
		check("oe after", 10'h00f, oe);
		check("addr load", 10'h009, addr);
		check("chan load", 10'h1ff, chan_n);
		pulse();
		check("chan step", 10'h2ff, chan_n);
	endtask : t_load
	task automatic t_touch;
		int i;
		@(posedge i_clk) touch <= 10'h008;
		cyc(4);
		check("mute touch", 10'h001, mute);
		for (i = 0; i < 100 && mute !== 1'b0; i++)
			cyc(1);
		if (i == 100) begin
			n_errors++;
			print_verdict();
		end
		@(posedge i_clk) touch <= 10'h000;
		cyc(4);
		check("chan touch", 10'h3f7, chan_n);
		check("addr touch", 10'h003, addr);
	endtask : t_touch
	task automatic t_six;
		logic [3:0] want;
		want = 4'h0;
		for (int k = 0; k < 6; k++) begin
			want = (want == 4'h5) ? 4'h0 : want + 4'h1;
			@(posedge i_clk) go_six <= 1'b1;
			@(posedge i_clk) go_six <= 1'b0;
			cyc(8);
			check("six addr", {6'h00, want}, addr);
		end
		check("six chan", 10'h3fe, chan_n);
	endtask : t_six
	task automatic t_exp;
		logic [3:0] v [3] = '{4'h6, 4'hf, 4'h5};
		logic [9:0] e [3] = '{10'h3fe, 10'h1ff, 10'h3ff};
		for (int k = 0; k < 3; k++) begin
			@(posedge i_clk) xaddr <= v[k];
			cyc(4);
			check("exp chan", e[k], xchan_n);
			check("exp addr", {6'h00, v[k]}, xout);
		end
	endtask : t_exp
	// Main sequence; the touch wait is bounded and ends the run on timeout.
	initial begin
		t_reset();
		t_step();
		t_load();
		t_touch();
		t_six();
		t_exp();
		print_verdict();
	end
endmodule : test_touch_channel_selector
